// ### hdl/bwcl_pkg.sv
package bwcl_pkg;
    localparam int          BWCL_FIFO_WIDTH    = 8;
    localparam int          BWCL_FIFO_DEPTH    = 16;
    localparam logic [7:0]  BWCL_FILL_BYTE     = 8'hFF;
    localparam logic [7:0]  BWCL_PREAMBLE      = 8'hF2;
    localparam logic [7:0]  BWCL_CHECK_BYTE    = 8'hD2;
    localparam logic [7:0]  BWCL_START_BYTE    = 8'hFE;
    localparam int          BWCL_COUNT_BYTES   = 3;
    localparam int          BWCL_EXTEND_BYTES  = 5;
    localparam int          BWCL_STARTUP_CLKS  = 4;
    localparam int          BWCL_FRAME_BYTES   = 8;
    localparam int          BWCL_FRAME_TOTAL   = 4;
    localparam logic        BWCL_CHAIN_RESET   = 1'b1;
    localparam logic        BWCL_MODE_HI_BYTE  = 1'b0;
    localparam int          BWCL_DONE_DELAY    = 2;

    typedef enum {
        BWCL_ST_SEARCH, BWCL_ST_COUNT, BWCL_ST_FCHECK, BWCL_ST_START,
        BWCL_ST_DATA, BWCL_ST_CHECK, BWCL_ST_EXTEND, BWCL_ST_STARTUP,
        BWCL_ST_DONE, BWCL_ST_ERROR
    } bwcl_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } bwcl_word_t;

    typedef struct packed {
        logic       error;
        logic       mem_full;
        logic       header_seen;
    } bwcl_status_t;
endpackage

// ### hdl/bwcl_fifo.sv
module bwcl_fifo
    import bwcl_pkg::*;
#(
    parameter int WIDTH = BWCL_FIFO_WIDTH,
    parameter int DEPTH = BWCL_FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rd_reg];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // bwcl_fifo

// ### hdl/bwcl_loader.sv
module bwcl_loader
    import bwcl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       configuration_clock,
    input  wire logic [7:0] config_byte_bus,
    input  wire logic       chain_select_in,
    input  wire logic       mode_select_hi,
    input  wire logic       mode_select_lo,
    input  wire logic       reconfig_n,
    input  wire logic       done_pullup_en,
    input  wire logic       done_in,
    output logic            done_out,
    output logic            done_oe_n,
    output logic            done_pullup,
    output logic            init_out,
    output logic            init_oe_n,
    output logic            chain_status_out,
    output logic            user_io_enable,
    output logic [7:0]      frame_data,
    output logic            frame_data_valid,
    input  wire logic       frame_data_ready,
    output bwcl_status_t    status
);
    logic [1:0]  clk_sync_reg;
    logic        clk_prev_reg;
    logic [7:0]  d0_reg;
    logic [7:0]  d1_reg;
    logic [1:0]  cs_sync_reg;
    logic [1:0]  mh_sync_reg;
    logic [1:0]  rc_sync_reg;
    logic [1:0]  dn_sync_reg;
    bwcl_state_t state_reg;
    bwcl_state_t state_next;
    logic [3:0]  byte_cnt_reg;
    logic [3:0]  byte_cnt_next;
    logic [15:0] frame_cnt_reg;
    logic [15:0] frame_cnt_next;
    logic        header_reg;
    logic        header_next;
    logic        error_reg;
    logic        error_next;
    logic        full_reg;
    logic        full_next;
    logic [7:0]  byte_hold_reg;
    logic        push_next;
    logic        push_reg;
    logic [1:0]  mode_wait_reg;
    logic        mode_ok_reg;
    logic        init_hi_reg;
    logic        in_ready;

    // Decoded views of the synchronised pins and of the byte taken.
    wire         clk_rise       = clk_sync_reg[1] && !clk_prev_reg;
    wire [7:0]   byte_in        = d1_reg;
    wire         cs_hi          = cs_sync_reg[1];
    wire         reconfig       = !rc_sync_reg[1];
    wire         done_seen      = dn_sync_reg[1];
    wire         mode_byte_wide = mh_sync_reg[1] == BWCL_MODE_HI_BYTE;
    wire         is_fill        = byte_in == BWCL_FILL_BYTE;
    wire         is_preamble    = byte_in == BWCL_PREAMBLE;
    wire         is_check       = byte_in == BWCL_CHECK_BYTE;
    wire         is_start       = byte_in == BWCL_START_BYTE;
    wire         last_frame     = frame_cnt_reg == 16'(BWCL_FRAME_TOTAL - 1);
    wire         in_done        = state_reg == BWCL_ST_DONE;
    wire         accept         = cs_hi && !full_reg;
    wire         stepping       = clk_rise && mode_ok_reg;

    // The link clock and the byte bus pass two flip-flops side by side, so they stay aligned.
    always_ff @(posedge mclk) begin
        if (reset) begin
            clk_sync_reg <= '0;
            clk_prev_reg <= 1'b0;
            d0_reg       <= '0;
            d1_reg       <= '0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], configuration_clock};
            clk_prev_reg <= clk_sync_reg[1];
            d0_reg       <= config_byte_bus;
            d1_reg       <= d0_reg;
        end
    end

    // Level pins pass two flip-flops and start at their idle levels, so no false restart follows reset.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cs_sync_reg <= '1;
            mh_sync_reg <= '0;
            rc_sync_reg <= '1;
            dn_sync_reg <= '0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], chain_select_in};
            mh_sync_reg <= {mh_sync_reg[0], mode_select_hi};
            rc_sync_reg <= {rc_sync_reg[0], reconfig_n};
            dn_sync_reg <= {dn_sync_reg[0], done_in};
        end
    end

    // Init is released at reset exit; the mode pin is sampled two clocks after init reads high.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            init_hi_reg   <= 1'b0;
            mode_wait_reg <= '0;
        end else begin
            init_hi_reg <= !error_reg;
            if (init_hi_reg && mode_wait_reg != 2'(BWCL_DONE_DELAY)) begin
                mode_wait_reg <= mode_wait_reg + 2'h1;
            end
        end
    end

    // The mode pin is read once; serial and master modes leave the parser idle.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            mode_ok_reg <= 1'b0;
        end else if (mode_wait_reg == 2'(BWCL_DONE_DELAY - 1)) begin
            mode_ok_reg <= mode_byte_wide;
        end
    end

    // The parser steps once for every rising configuration clock edge seen, and only once the mode is accepted.
    always_comb begin
        state_next     = state_reg;
        byte_cnt_next  = byte_cnt_reg;
        frame_cnt_next = frame_cnt_reg;
        header_next    = header_reg;
        error_next     = error_reg;
        full_next      = full_reg;
        push_next      = 1'b0;
        if (stepping) begin
            unique case (state_reg)
                BWCL_ST_SEARCH: begin
                    if (is_preamble) begin
                        state_next    = BWCL_ST_COUNT;
                        byte_cnt_next = '0;
                    end else if (!is_fill) begin
                        error_next = 1'b1;
                        state_next = BWCL_ST_ERROR;
                    end
                end
                BWCL_ST_COUNT: begin
                    byte_cnt_next = byte_cnt_reg + 4'h1;
                    if (byte_cnt_reg == 4'(BWCL_COUNT_BYTES - 1)) begin
                        state_next = BWCL_ST_FCHECK;
                    end
                end
                BWCL_ST_FCHECK: begin
                    if (is_check) begin
                        state_next  = BWCL_ST_START;
                        header_next = 1'b1;
                    end else if (!is_fill) begin
                        error_next = 1'b1;
                        state_next = BWCL_ST_ERROR;
                    end
                end
                BWCL_ST_START: begin
                    if (full_reg) begin
                        state_next    = BWCL_ST_STARTUP;
                        byte_cnt_next = '0;
                    end else if (accept && is_start) begin
                        state_next    = BWCL_ST_DATA;
                        byte_cnt_next = '0;
                    end
                end
                BWCL_ST_DATA: begin
                    push_next     = in_ready;
                    byte_cnt_next = byte_cnt_reg + 4'h1;
                    if (!in_ready) begin
                        error_next = 1'b1;
                        state_next = BWCL_ST_ERROR;
                    end else if (byte_cnt_reg == 4'(BWCL_FRAME_BYTES - 1)) begin
                        state_next = BWCL_ST_CHECK;
                    end
                end
                BWCL_ST_CHECK: begin
                    if (!is_check) begin
                        error_next = 1'b1;
                        state_next = BWCL_ST_ERROR;
                    end else begin
                        frame_cnt_next = frame_cnt_reg + 16'h1;
                        full_next      = last_frame;
                        state_next     = BWCL_ST_EXTEND;
                        byte_cnt_next  = '0;
                    end
                end
                BWCL_ST_EXTEND: begin
                    byte_cnt_next = byte_cnt_reg + 4'h1;
                    if (byte_cnt_reg == 4'(BWCL_EXTEND_BYTES - 1)) begin
                        state_next    = full_reg ? BWCL_ST_STARTUP : BWCL_ST_START;
                        byte_cnt_next = '0;
                    end
                end
                BWCL_ST_STARTUP: begin
                    byte_cnt_next = byte_cnt_reg + 4'h1;
                    if (byte_cnt_reg == 4'(BWCL_STARTUP_CLKS - 1)) begin
                        state_next = BWCL_ST_DONE;
                    end
                end
                BWCL_ST_DONE: begin
                end
                BWCL_ST_ERROR: begin
                end
            endcase
        end
    end

    // Parser state and its byte counter.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            state_reg    <= BWCL_ST_SEARCH;
            byte_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            byte_cnt_reg <= byte_cnt_next;
        end
    end

    // Frames taken and the memory-full flag.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            frame_cnt_reg <= '0;
            full_reg      <= 1'b0;
        end else begin
            frame_cnt_reg <= frame_cnt_next;
            full_reg      <= full_next;
        end
    end

    // Header and error flags.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            header_reg <= 1'b0;
            error_reg  <= 1'b0;
        end else begin
            header_reg <= header_next;
            error_reg  <= error_next;
        end
    end

    // Byte handed to the FIFO one clock after the parser took it.
    always_ff @(posedge mclk) begin
        if (reset || reconfig) begin
            push_reg      <= 1'b0;
            byte_hold_reg <= '0;
        end else begin
            push_reg      <= push_next;
            byte_hold_reg <= byte_in;
        end
    end

    // Frame bytes wait here until the logic behind the loader drains them.
    bwcl_fifo #(
        .WIDTH (BWCL_FIFO_WIDTH),
        .DEPTH (BWCL_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_data   (byte_hold_reg),
        .in_valid  (push_reg),
        .in_ready  (in_ready),
        .out_data  (frame_data),
        .out_valid (frame_data_valid),
        .out_ready (frame_data_ready)
    );

    // Done is open-drain: low is driven while not finished, high is released.
    assign done_out         = 1'b0;
    assign done_oe_n        = in_done;
    assign done_pullup      = done_pullup_en;
    assign init_out         = 1'b0;
    assign init_oe_n        = !error_reg;
    assign chain_status_out = header_reg ? full_reg : BWCL_CHAIN_RESET;
    assign user_io_enable   = in_done && done_seen;
    assign status           = '{error: error_reg, mem_full: full_reg, header_seen: header_reg};
endmodule // bwcl_loader

// ### testbench/bwcl_loader_assertions.sv
module bwcl_loader_assertions
    import bwcl_pkg::*;
(
    input wire logic         mclk,
    input wire logic         reset,
    input wire logic         reconfig_n,
    input wire logic         done_pullup_en,
    input wire logic         done_in,
    input wire logic         done_out,
    input wire logic         done_oe_n,
    input wire logic         done_pullup,
    input wire logic         init_out,
    input wire logic         init_oe_n,
    input wire logic         chain_status_out,
    input wire logic         user_io_enable,
    input wire logic [7:0]   frame_data,
    input wire logic         frame_data_valid,
    input wire logic         frame_data_ready,
    input wire bwcl_status_t status
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    done_low_a: assert property (done_out == 1'b0) else $error("done driven high");
    pullup_follow_a: assert property (done_pullup == done_pullup_en) else $error("done pull-up wrong");
    init_low_a: assert property (init_out == 1'b0) else $error("init driven high");
    error_init_a: assert property ($rose(status.error) |-> ##[0:2] !init_oe_n) else $error("init not pulled");
    error_nodone_a: assert property (status.error |-> !done_oe_n) else $error("done released on error");
    header_chain_a: assert property ($rose(status.header_seen) |-> ##[0:2] !chain_status_out)
        else $error("chain status not low");
    full_chain_a: assert property ($rose(status.mem_full) |-> ##[0:2] chain_status_out)
        else $error("chain status not high");
    done_full_a: assert property ($rose(done_oe_n) |-> status.mem_full) else $error("done before full");
    io_done_a: assert property ($rose(user_io_enable) |-> done_oe_n && $past(done_in))
        else $error("user io early");
    fifo_hold_a: assert property (frame_data_valid && !frame_data_ready |=> frame_data_valid && $stable(frame_data))
        else $error("output word dropped");
    full_stand_a: assert property (status.mem_full && reconfig_n |=> status.mem_full)
        else $error("full flag lost");
endmodule // bwcl_loader_assertions

// ### testbench/bwcl_source.sv
module bwcl_source (
    output logic       configuration_clock,
    output logic [7:0] config_byte_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        configuration_clock = 1'b0;
        config_byte_bus     = 8'h5A;
    end
    // Sends one byte; the clock stands low between bytes.
    task automatic put(input logic [7:0] b);
        config_byte_bus = b;
        #16 configuration_clock = 1'b1;
        #16 configuration_clock = 1'b0;
    endtask
    // Releases the bus, which then shows the inverse of the last byte.
    task automatic idle();
        config_byte_bus = ~config_byte_bus;
    endtask
endmodule // bwcl_source

// ### testbench/tb_bwcl_loader.sv
module tb_bwcl_loader
    import bwcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic         mclk, reset, chain_select_in, mode_select_hi, mode_select_lo, reconfig_n;
    logic         done_pullup_en, frame_data_ready, ext_low, configuration_clock;
    logic         done_out, done_oe_n, done_pullup, init_out, init_oe_n, chain_status_out;
    logic         user_io_enable, frame_data_valid;
    logic [7:0]   config_byte_bus, frame_data;
    bwcl_status_t status;
    wire          done_in;
    logic [7:0]   exp_q[$];
    int           error_cnt, checked, cycles;
    int           seed = 4458;
    assign done_in = done_oe_n && !ext_low;
    bwcl_source i_src (.configuration_clock(configuration_clock), .config_byte_bus(config_byte_bus));
    bwcl_loader i_bwcl_loader (.mclk(mclk), .reset(reset), .configuration_clock(configuration_clock),
        .config_byte_bus(config_byte_bus), .chain_select_in(chain_select_in), .mode_select_hi(mode_select_hi),
        .mode_select_lo(mode_select_lo), .reconfig_n(reconfig_n), .done_pullup_en(done_pullup_en),
        .done_in(done_in), .done_out(done_out), .done_oe_n(done_oe_n), .done_pullup(done_pullup),
        .init_out(init_out), .init_oe_n(init_oe_n), .chain_status_out(chain_status_out),
        .user_io_enable(user_io_enable), .frame_data(frame_data), .frame_data_valid(frame_data_valid),
        .frame_data_ready(frame_data_ready), .status(status));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic restart();
        reconfig_n = 1'b0;
        tick(4);
        reconfig_n = 1'b1;
        tick(10);
    endtask
    task automatic stream(input bit bad, input bit acc);
        logic [7:0] d;
        repeat (2) i_src.put(BWCL_FILL_BYTE);
        i_src.put(BWCL_PREAMBLE);
        repeat (BWCL_COUNT_BYTES) i_src.put(8'($random(seed)));
        repeat (3) i_src.put(BWCL_FILL_BYTE);
        i_src.put(BWCL_CHECK_BYTE);
        tick(8);
        chk("chain_after_header", 0, chain_status_out);
        for (int f = 0; f < BWCL_FRAME_TOTAL; f++) begin
            i_src.put(BWCL_START_BYTE);
            repeat (BWCL_FRAME_BYTES) begin
                d = 8'($random(seed));
                if (acc) exp_q.push_back(d);
                i_src.put(d);
            end
            i_src.put(bad ? 8'hD3 : BWCL_CHECK_BYTE);
            if (bad) break;
            repeat (BWCL_EXTEND_BYTES) i_src.put(BWCL_FILL_BYTE);
        end
        if (!bad) repeat (BWCL_STARTUP_CLKS) i_src.put(8'($random(seed)));
        i_src.idle();
        tick(20);
    endtask
    always @(posedge mclk) begin
        #1;
        frame_data_ready = 1'($random(seed));
        mode_select_lo = 1'($random(seed));
        done_pullup_en = 1'($random(seed));
    end
    always @(posedge mclk) begin
        if (frame_data_valid === 1'b1 && frame_data_ready === 1'b1) begin
            checked++;
            if (exp_q.size() == 0 || frame_data !== exp_q[0]) begin
                $display("CHECK FAILED frame_data expected %h seen %h", exp_q.size() ? exp_q[0] : 8'h00, frame_data);
                error_cnt++;
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        reset = 1'b1;
        reconfig_n = 1'b1;
        chain_select_in = 1'b1;
        mode_select_hi = BWCL_MODE_HI_BYTE;
        mode_select_lo = 1'b0;
        done_pullup_en = 1'b1;
        frame_data_ready = 1'b0;
        ext_low = 1'b0;
        tick(5);
        reset = 1'b0;
        tick(10);
        chk("chain_idle", 1, chain_status_out);
        stream(0, 1);
        chk("mem_full", 1, status.mem_full);
        chk("chain_full", 1, chain_status_out);
        chk("done_release", 1, done_oe_n);
        chk("user_io", 1, user_io_enable);
        restart();
        ext_low = 1'b1;
        stream(0, 1);
        chk("done_release_held", 1, done_oe_n);
        chk("user_io_held", 0, user_io_enable);
        ext_low = 1'b0;
        tick(10);
        chk("user_io_late", 1, user_io_enable);
        restart();
        stream(1, 1);
        chk("error", 1, status.error);
        chk("init_low", 0, init_oe_n);
        chk("done_held", 0, done_oe_n);
        restart();
        chk("init_cleared", 1, init_oe_n);
        chk("error_cleared", 0, status.error);
        chain_select_in = 1'b0;
        stream(0, 0);
        chk("mem_not_full", 0, status.mem_full);
        chk("chain_low", 0, chain_status_out);
        chk("data_left", 0, 32'(exp_q.size()));
        mode_select_hi = 1'b1;
        restart();
        i_src.put(BWCL_PREAMBLE);
        repeat (BWCL_COUNT_BYTES + 1) i_src.put(BWCL_FILL_BYTE);
        i_src.put(BWCL_CHECK_BYTE);
        tick(8);
        chk("mode_off_header", 0, status.header_seen);
        chk("mode_off_chain", 1, chain_status_out);
        give_verdict();
    end
endmodule // tb_bwcl_loader
bind bwcl_loader bwcl_loader_assertions i_bwcl_loader_assertions (.mclk(mclk), .reset(reset),
    .reconfig_n(reconfig_n), .done_pullup_en(done_pullup_en), .done_in(done_in), .done_out(done_out),
    .done_oe_n(done_oe_n), .done_pullup(done_pullup), .init_out(init_out), .init_oe_n(init_oe_n),
    .chain_status_out(chain_status_out), .user_io_enable(user_io_enable), .frame_data(frame_data),
    .frame_data_valid(frame_data_valid), .frame_data_ready(frame_data_ready), .status(status));
